// *** hw/tmc_defs.svh ***
/*
  Register offsets, reset values, field positions and timing counts for the
  temperature monitor configuration and shutdown block.
  Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// ============================================================
// register offsets
`define TMC_A_REC       8'h17
`define TMC_A_CRIT_E1   8'h19
`define TMC_A_CRIT_E2   8'h1A
`define TMC_A_CRIT_E3   8'h1B
`define TMC_A_CRIT_IN   8'h1D
`define TMC_A_CRIT_ST   8'h1F
`define TMC_A_MAIN      8'h20
`define TMC_A_CONV      8'h21

// ============================================================
// reset values
`define TMC_RST_REC     3'h4
`define TMC_RST_CRIT    8'h64
`define TMC_RST_MAIN    8'h00
`define TMC_RST_CONV    8'h0E

// ============================================================
// field positions
`define TMC_B_CORR1     0
`define TMC_B_CORR2     1

// ============================================================
// timing
`define TMC_CLK_HZ      50000
`define TMC_CONV_MS_1   1000
`define TMC_CONV_MS_2   500
`define TMC_CONV_MS_4   250
`define TMC_MS_CYC(ms)  ((ms) * `TMC_CLK_HZ)

`endif

// *** hw/tmc_pkg.sv ***
/*
  Types of the temperature monitor configuration and shutdown block.
  Assumes nothing of its surroundings.
*/
package tmc_pkg;

  // ============================================================
  // register layouts
  typedef struct packed {
    logic       mask;
    logic [2:0] rsv;
    logic       ext3_high_to_shutdown;
    logic       ext2_high_to_shutdown;
    logic       ext1_high_to_shutdown;
    logic       antiparallel_diode_en;
  } tmc_main_cfg_t;

  typedef struct packed {
    logic       rsv;
    logic       dyn_off;
    logic       to_off;
    logic       avg_off;
    logic [1:0] queue;
    logic [1:0] rate;
  } tmc_conv_cfg_t;

  // ============================================================
  // register access carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmc_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tmc_reg_rsp_t;

  typedef logic signed [7:0] tmc_temp_t;

  typedef enum logic [1:0] {APD_OFF, APD_SKIP, APD_SETTLE, APD_LIVE} tmc_apd_st_t;
  typedef enum logic [1:0] {SHDN_INT, SHDN_EXT1, SHDN_EXT2, SHDN_NONE} tmc_shdn_chan_t;

  // ============================================================
  // module state
  typedef struct packed {
    logic [2:0]      fill;
    logic [1:0]      wp;
    logic [3:0][7:0] buf_w;
    logic [7:0]      out;
  } tmc_avg_st_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [2:0] depth;
    logic       trip;
  } tmc_fq_st_t;

  typedef struct packed {
    logic [2:0]      resistance_error_correction;
    logic [2:0]      rec_out;
    logic [3:0][7:0] crit;
    logic [3:0]      linked;
    tmc_main_cfg_t   main;
    tmc_conv_cfg_t   conv;
    logic [3:0]      tst;
    tmc_apd_st_t     antiparallel_diode_en;
    logic            shdn;
    logic            alert_n;
    tmc_reg_rsp_t    rsp;
    logic            rvld;
    logic [25:0]     cnt;
    logic            tick;
  } tmc_top_st_t;

endpackage : tmc_pkg

// *** hw/tmc_fault_queue.sv ***
/*
  One fault queue: counts consecutive samples that meet its condition.
  Assumes sample is a one-cycle pulse per completed update.
*/
module tmc_fault_queue
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // sample
  input  wire logic       sample,
  input  wire logic       cond,
  input  wire logic [1:0] depth_sel,
  // result
  output logic            trip
);

  tmc_fq_st_t st_q;
  tmc_fq_st_t nx;
  logic [2:0] depth;

  always_comb begin
    nx = st_q;
    nx.trip = 1'b0;
    // new depth only taken while the queue is empty
    depth = (st_q.cnt == 3'h0) ? ({1'b0, depth_sel} + 3'h1) : st_q.depth;
    nx.depth = depth;
    if (sample) begin
      if (!cond) begin
        nx.cnt = 3'h0;
      end else if (st_q.cnt + 3'h1 >= depth) begin
        nx.cnt = 3'h0;
        nx.trip = 1'b1;
      end else begin
        nx.cnt = st_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{depth: 3'h4, default: '0};
    end else if (ce) begin
      st_q <= nx;
    end
  end

  assign trip = st_q.trip;

endmodule : tmc_fault_queue

// *** hw/tmc_mean4.sv ***
/*
  Reported temperature: mean of the last four samples or the latest one.
  Assumes sample is a one-cycle pulse with valid data.
*/
module tmc_mean4
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      ce,
  // sample in
  input  wire logic      sample,
  input  tmc_temp_t      din,
  input  wire logic      avg_off,
  // report
  output tmc_temp_t      dout
);

  tmc_avg_st_t      st_q;
  tmc_avg_st_t      nx;
  logic signed [9:0] sum;

  always_comb begin
    nx = st_q;
    sum = 10'sh000;
    if (sample) begin
      nx.buf_w[st_q.wp] = din;
      nx.wp = st_q.wp + 2'h1;
      nx.fill = (st_q.fill == 3'h4) ? 3'h4 : st_q.fill + 3'h1;
      for (int i = 0; i < 4; i++) begin
        sum = sum + 10'($signed(nx.buf_w[i]));
      end
      // until four samples exist the latest one is reported
      nx.out = (avg_off || nx.fill != 3'h4) ? din : sum[9:2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= nx;
    end
  end

  assign dout = st_q.out;

endmodule : tmc_mean4

// *** hw/tmc_config_shutdown.sv ***
/*
  Configuration registers and critical shutdown logic of a four-channel
  temperature monitor. Channel index 0 is internal, 1..3 external.
  Assumes the serial engine delivers one-cycle register strobes and that
  measured samples, limits and other status arrive synchronous to CLK.
*/
`include "tmc_defs.svh"
module tmc_config_shutdown
  import tmc_pkg::*;
#(
  parameter int CONV_CYC_1 = `TMC_MS_CYC(`TMC_CONV_MS_1),
  parameter int CONV_CYC_2 = `TMC_MS_CYC(`TMC_CONV_MS_2),
  parameter int CONV_CYC_4 = `TMC_MS_CYC(`TMC_CONV_MS_4)
) (
  // clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CE,
  // register access
  input  tmc_reg_req_t              REG_REQ,
  output tmc_reg_rsp_t              REG_RSP,
  input  wire logic                 SW_LOCK,
  // shutdown channel straps
  input  tmc_shdn_chan_t            HW_SHDN_CHAN,
  input  wire logic                 SHUTDOWN_CHANNEL_SELECT_PIN,
  // measurement
  input  tmc_temp_t [3:0]           TEMP_RAW,
  input  wire logic                 TEMP_VALID,
  input  tmc_temp_t [3:0]           HIGH_LIMIT,
  input  tmc_temp_t [3:0]           LOW_LIMIT,
  input  wire logic [3:0]           DIODE_FAULT,
  // alert sources
  input  wire logic [3:0]           CHAN_INT_EN,
  input  wire logic [7:0]           OTHER_STATUS,
  // results
  output tmc_temp_t [3:0]           TEMP_REPORT,
  output logic [11:0]               QUEUE_TRIP,
  output logic                      SYSTEM_SHUTDOWN_OUT,
  output logic                      ALERT_N,
  output logic                      TCRIT_SUMMARY,
  output logic [3:0]                CRIT_LINKED,
  output logic [2:0]                RESIST_CORRECT_EN,
  output tmc_main_cfg_t             MAIN_CFG,
  output tmc_conv_cfg_t             CONV_CFG,
  output logic                      CONV_TICK,
  output logic                      EXT3_CMP_EN
);

  // ============================================================
  // decoding
  function automatic logic [2:0] crit_sel(input logic [7:0] a);
    case (a)
      `TMC_A_CRIT_IN: crit_sel = 3'h4;
      `TMC_A_CRIT_E1: crit_sel = 3'h5;
      `TMC_A_CRIT_E2: crit_sel = 3'h6;
      `TMC_A_CRIT_E3: crit_sel = 3'h7;
      default:        crit_sel = 3'h0;
    endcase
  endfunction : crit_sel

  function automatic logic [25:0] conv_period(input logic [1:0] r);
    case (r)
      2'h0:    conv_period = 26'(CONV_CYC_1 - 1);
      2'h1:    conv_period = 26'(CONV_CYC_2 - 1);
      default: conv_period = 26'(CONV_CYC_4 - 1);
    endcase
  endfunction : conv_period

  localparam tmc_top_st_t ST_RST = '{
    resistance_error_correction:     `TMC_RST_REC,
    crit:    {4{`TMC_RST_CRIT}},
    main:    `TMC_RST_MAIN,
    conv:    `TMC_RST_CONV,
    antiparallel_diode_en:     APD_OFF,
    alert_n: 1'b1,
    default: '0
  };

  tmc_top_st_t     st_q;
  tmc_top_st_t     nx;
  tmc_temp_t [3:0] rpt;
  logic [3:0]      chan_en;
  logic [3:0]      over;
  logic [3:0]      hi_hit;
  logic [3:0]      tset;
  logic [3:0]      tclr;
  logic [11:0]     qcond;
  logic [2:0]      csel;
  logic            wr_ok;
  logic            lock1;
  logic            lock2;

  // ============================================================
  // per-channel averaging (external channels only) and fault queues
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      tmc_mean4 u_mean (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .sample  (TEMP_VALID),
        .din     (TEMP_RAW[g]),
        .avg_off (st_q.conv.avg_off || (g == 0)),
        .dout    (rpt[g])
      );
      assign over[g]   = chan_en[g] && ($signed(rpt[g]) > $signed(st_q.crit[g]));
      assign hi_hit[g] = chan_en[g] && ($signed(rpt[g]) >= $signed(HIGH_LIMIT[g]));
      assign qcond[g]     = hi_hit[g];
      assign qcond[g + 4] = chan_en[g] && ($signed(rpt[g]) < $signed(LOW_LIMIT[g]));
      assign qcond[g + 8] = chan_en[g] && DIODE_FAULT[g];
    end
    for (g = 0; g < 12; g++) begin : g_queue
      tmc_fault_queue u_fq (
        .clk       (CLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .sample    (st_q.rvld),
        .cond      (qcond[g]),
        .depth_sel (st_q.conv.queue),
        .trip      (QUEUE_TRIP[g])
      );
    end
  endgenerate

  // channel 3 compares stay off until a full update after enabling
  assign chan_en = {(!st_q.main.antiparallel_diode_en || st_q.antiparallel_diode_en == APD_LIVE), 3'h7};

  // ============================================================
  // next state
  always_comb begin
    nx = st_q;
    csel = crit_sel(REG_REQ.addr);
    wr_ok = REG_REQ.wr && !SW_LOCK;
    lock1 = (HW_SHDN_CHAN == SHDN_EXT1);
    lock2 = (HW_SHDN_CHAN == SHDN_EXT2);

    // lockable configuration writes
    if (wr_ok && REG_REQ.addr == `TMC_A_REC) begin
      nx.resistance_error_correction = REG_REQ.wdata[2:0];
      // bits owned by the shutdown pin keep their value
      if (lock1) begin
        nx.resistance_error_correction[`TMC_B_CORR1] = st_q.resistance_error_correction[`TMC_B_CORR1];
      end
      if (lock2) begin
        nx.resistance_error_correction[`TMC_B_CORR2] = st_q.resistance_error_correction[`TMC_B_CORR2];
      end
    end
    if (wr_ok && REG_REQ.addr == `TMC_A_MAIN) begin
      nx.main = REG_REQ.wdata;
      nx.main.rsv = 3'h0;
    end
    if (wr_ok && REG_REQ.addr == `TMC_A_CONV) begin
      nx.conv = REG_REQ.wdata;
      nx.conv.rsv = 1'b0;
    end

    // write-once critical limits, not software lockable
    if (REG_REQ.wr && csel[2] && !st_q.linked[csel[1:0]]) begin
      nx.crit[csel[1:0]] = REG_REQ.wdata;
      nx.linked[csel[1:0]] = 1'b1;
    end

    nx.rec_out = st_q.resistance_error_correction;
    if (lock1) begin
      nx.rec_out[`TMC_B_CORR1] = SHUTDOWN_CHANNEL_SELECT_PIN;
    end
    if (lock2) begin
      nx.rec_out[`TMC_B_CORR2] = SHUTDOWN_CHANNEL_SELECT_PIN;
    end

    // sticky critical status, set wins over the read clear
    tset = st_q.linked & over;
    tclr = (REG_REQ.rd && REG_REQ.addr == `TMC_A_CRIT_ST) ? 4'hF : 4'h0;
    nx.tst = (st_q.tst & ~tclr) | tset;

    // shutdown is a level: released as soon as no cause remains
    nx.shdn = (|tset)
           || (|({st_q.main.ext3_high_to_shutdown, st_q.main.ext2_high_to_shutdown, st_q.main.ext1_high_to_shutdown} & hi_hit[3:1]));

    nx.alert_n = !(!st_q.main.mask
                  && ((|(st_q.tst & CHAN_INT_EN)) || (|OTHER_STATUS)));

    // register read, answered one cycle later
    nx.rsp.valid = REG_REQ.rd;
    nx.rsp.data = 8'h00;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `TMC_A_REC:     nx.rsp.data = {5'h00, st_q.rec_out};
        `TMC_A_CRIT_ST: nx.rsp.data = {4'h0, st_q.tst};
        `TMC_A_MAIN:    nx.rsp.data = st_q.main;
        `TMC_A_CONV:    nx.rsp.data = st_q.conv;
        default: begin
          if (csel[2]) begin
            nx.rsp.data = st_q.crit[csel[1:0]];
          end
        end
      endcase
    end

    // anti-parallel settle: the update in flight is partial, wait for the next
    case (st_q.antiparallel_diode_en)
      APD_OFF:    nx.antiparallel_diode_en = st_q.main.antiparallel_diode_en ? APD_SKIP : APD_OFF;
      APD_SKIP:   nx.antiparallel_diode_en = TEMP_VALID ? APD_SETTLE : APD_SKIP;
      APD_SETTLE: nx.antiparallel_diode_en = TEMP_VALID ? APD_LIVE : APD_SETTLE;
      APD_LIVE:   nx.antiparallel_diode_en = APD_LIVE;
      default:    nx.antiparallel_diode_en = APD_OFF;
    endcase
    if (!st_q.main.antiparallel_diode_en) begin
      nx.antiparallel_diode_en = APD_OFF;
    end

    nx.rvld = TEMP_VALID;

    // conversion pacing; continuous mode restarts on each finished update
    nx.tick = 1'b0;
    if (st_q.conv.rate == 2'h3) begin
      nx.cnt = 26'h0000000;
      nx.tick = TEMP_VALID;
    end else if (st_q.cnt >= conv_period(st_q.conv.rate)) begin
      nx.cnt = 26'h0000000;
      nx.tick = 1'b1;
    end else begin
      nx.cnt = st_q.cnt + 26'h0000001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_RST;
    end else if (CE) begin
      st_q <= nx;
    end
  end

  // ============================================================
  // outputs
  assign REG_RSP             = st_q.rsp;
  assign TEMP_REPORT         = rpt;
  assign SYSTEM_SHUTDOWN_OUT = st_q.shdn;
  assign ALERT_N             = st_q.alert_n;
  assign TCRIT_SUMMARY       = |st_q.tst;
  assign CRIT_LINKED         = st_q.linked;
  assign RESIST_CORRECT_EN   = st_q.rec_out;
  assign MAIN_CFG            = st_q.main;
  assign CONV_CFG            = st_q.conv;
  assign CONV_TICK           = st_q.tick;
  assign EXT3_CMP_EN         = chan_en[3];

  // ============================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_CORR_PIN: assert property (
    CE && HW_SHDN_CHAN == SHDN_EXT1 |=> RESIST_CORRECT_EN[0] == $past(SHUTDOWN_CHANNEL_SELECT_PIN)
  ) else $error("correction enable does not follow shutdown pin");

  AST_LOCK_MAIN: assert property (
    CE && SW_LOCK && REG_REQ.wr && REG_REQ.addr == `TMC_A_MAIN |=> $stable(MAIN_CFG)
  ) else $error("locked configuration write took effect");

  AST_CRIT_ONCE: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == `TMC_A_CRIT_E1 && CRIT_LINKED[1]
      |=> $stable(st_q.crit[1])
  ) else $error("critical limit rewritten after lock");

  AST_CRIT_LINK: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == `TMC_A_CRIT_E1
      |=> CRIT_LINKED[1] && st_q.crit[1] == $past(REG_REQ.wdata) || $past(CRIT_LINKED[1])
  ) else $error("first critical write did not store and link");

  AST_SHDN_CRIT: assert property (
    CE && CRIT_LINKED[1] && over[1] |=> SYSTEM_SHUTDOWN_OUT && st_q.tst[1] && TCRIT_SUMMARY
  ) else $error("linked over-limit missed shutdown");

  AST_TST_STICKY: assert property (
    st_q.tst[1] && !(CE && REG_REQ.rd && REG_REQ.addr == `TMC_A_CRIT_ST) |=> st_q.tst[1]
  ) else $error("critical status lost without read");

  AST_ALERT_MASK: assert property (
    CE && MAIN_CFG.mask |=> ALERT_N
  ) else $error("alert asserted while masked");

  AST_APD_WAIT: assert property (
    $rose(MAIN_CFG.antiparallel_diode_en) |-> !EXT3_CMP_EN [*2]
  ) else $error("channel 3 compared before settle update");

  AST_HIGH_REL: assert property (
    CE && st_q.linked == 4'h0 && !(|hi_hit[3:1]) |=> !SYSTEM_SHUTDOWN_OUT
  ) else $error("shutdown held with no cause");

  AST_HIGH_SHDN: assert property (
    CE && MAIN_CFG.ext2_high_to_shutdown && hi_hit[2] |=> SYSTEM_SHUTDOWN_OUT
  ) else $error("high-limit link missed shutdown");

  AST_REC_RO: assert property (
    CE && HW_SHDN_CHAN == SHDN_EXT1 && REG_REQ.wr && REG_REQ.addr == `TMC_A_REC |=> $stable(st_q.resistance_error_correction[0])
  ) else $error("read-only correction bit was written");

  AST_LOCK_CONV: assert property (
    CE && SW_LOCK && REG_REQ.wr && REG_REQ.addr == `TMC_A_CONV |=> $stable(CONV_CFG)
  ) else $error("locked conversion write took effect");

  AST_LOCK_REC: assert property (
    CE && SW_LOCK && REG_REQ.wr && REG_REQ.addr == `TMC_A_REC |=> $stable(st_q.resistance_error_correction)
  ) else $error("locked correction write took effect");

  AST_TICK_CONT: assert property (
    CE && CONV_CFG.rate == 2'h3 && TEMP_VALID |=> CONV_TICK
  ) else $error("continuous mode missed a conversion start");

  AST_MASK_OFF: assert property (
    CE && !MAIN_CFG.mask && |OTHER_STATUS |=> !ALERT_N
  ) else $error("unmasked status did not assert alert");

  AST_UNLINKED_QUIET: assert property (
    !CRIT_LINKED[3] |-> !st_q.tst[3]
  ) else $error("unlinked channel set critical status");

  COV_SHDN: cover property ($rose(SYSTEM_SHUTDOWN_OUT));
  COV_TST_CLR: cover property ($fell(TCRIT_SUMMARY));
  COV_APD_LIVE: cover property (MAIN_CFG.antiparallel_diode_en && EXT3_CMP_EN);
  COV_QUEUE_TRIP: cover property (|QUEUE_TRIP);
  COV_HIGH_SHDN: cover property (MAIN_CFG.ext2_high_to_shutdown && SYSTEM_SHUTDOWN_OUT);

endmodule : tmc_config_shutdown

// *** verif/tmc_host.sv ***
/*
  Register host model: issues single-byte writes and reads on the strobe bus.
  Assumes the block takes a strobe at the rising edge and answers a read
  exactly one cycle later.
*/
module tmc_host
  import tmc_pkg::*;
(
  // clock
  input  wire logic   clk,
  // register bus
  output tmc_reg_req_t req,
  input  tmc_reg_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req = '0;
  end

  // ==========================================================
  // bus cycles
  // released address and data are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(negedge clk);
    d = (rsp.valid === 1'b1) ? rsp.data : 8'hEE;
  endtask : rd
endmodule : tmc_host

// *** verif/tb_tmc_config_shutdown.sv ***
/*
  Self-checking bench of the configuration and shutdown block.
  Assumes the host model drives the register bus; short conversion counts.
*/
`include "tmc_defs.svh"
module tb_tmc_config_shutdown
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus and observation
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           sw_lock = 1'b0;
  logic           ce = 1'b1;
  logic           valid = 1'b0;
  logic           pin = 1'b0;
  logic [3:0]     chan_en = 4'h0;
  logic [7:0]     other = 8'h00;
  logic [3:0]     dfault = 4'h0;
  tmc_shdn_chan_t hw_chan = SHDN_NONE;
  tmc_temp_t [3:0] raw = {4{8'sh10}};
  tmc_temp_t [3:0] hi = {8'sh7F, 8'sh40, 8'sh7F, 8'sh30};
  tmc_temp_t [3:0] lo = {4{8'sh80}};
  tmc_reg_req_t   req;
  tmc_reg_rsp_t   rsp;
  tmc_temp_t [3:0] rep;
  logic [11:0]    qtrip;
  logic           shdn, alert_n, tsum, tick, cmp3;
  logic [3:0]     linked;
  logic [2:0]     rec_en;
  tmc_main_cfg_t  main_cfg;
  tmc_conv_cfg_t  conv_cfg;
  logic [7:0]     d;
  logic           qt;
  int             n_mismatch = 0;
  int             n_compared = 0;

  always #10 clk = ~clk;

  tmc_host i_tmc_host (.clk(clk), .req(req), .rsp(rsp));

  tmc_config_shutdown #(.CONV_CYC_1(40), .CONV_CYC_2(20), .CONV_CYC_4(10))
  i_tmc_config_shutdown (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .REG_REQ(req), .REG_RSP(rsp),
    .SW_LOCK(sw_lock), .HW_SHDN_CHAN(hw_chan), .SHUTDOWN_CHANNEL_SELECT_PIN(pin),
    .TEMP_RAW(raw), .TEMP_VALID(valid), .HIGH_LIMIT(hi), .LOW_LIMIT(lo),
    .DIODE_FAULT(dfault), .CHAN_INT_EN(chan_en), .OTHER_STATUS(other),
    .TEMP_REPORT(rep), .QUEUE_TRIP(qtrip), .SYSTEM_SHUTDOWN_OUT(shdn),
    .ALERT_N(alert_n), .TCRIT_SUMMARY(tsum), .CRIT_LINKED(linked),
    .RESIST_CORRECT_EN(rec_en), .MAIN_CFG(main_cfg), .CONV_CFG(conv_cfg),
    .CONV_TICK(tick), .EXT3_CMP_EN(cmp3));

  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // queue trips and shutdown land two cycles after the edge that drives valid for each update, the report one cycle
  task automatic feed(input int ch, input logic [7:0] t, input int n);
    repeat (n) begin
      @(posedge clk);
      valid <= 1'b1;
      raw[ch] <= t;
      @(posedge clk);
      valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      // trip stands for one cycle only
      qt = qtrip[0];
      @(posedge clk);
      @(negedge clk);
    end
  endtask : feed

  task automatic period(input int exp);
    int c;
    for (int k = 0; k < 2; k++) begin
      c = 1;
      @(negedge clk);
      while (tick !== 1'b1 && c < 200) begin
        @(negedge clk);
        c++;
      end
    end
    chk("tick period", 8'(c), 8'(exp));
  endtask : period

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] exp [5] = '{8'h04, 8'h64, 8'h64, 8'h64, 8'h64};
    logic [7:0] adr [5] = '{`TMC_A_REC, `TMC_A_CRIT_E1, `TMC_A_CRIT_E2,
                            `TMC_A_CRIT_E3, `TMC_A_CRIT_IN};
    for (int i = 0; i < 5; i++) begin
      i_tmc_host.rd(adr[i], d);
      chk("reset value", d, exp[i]);
    end
    i_tmc_host.rd(`TMC_A_MAIN, d);
    chk("main reset", d, 8'h00);
    i_tmc_host.rd(`TMC_A_CONV, d);
    chk("conv reset", d, 8'h0E);
    i_tmc_host.rd(8'h30, d);
    chk("unmapped", d, 8'h00);
    chk("linked", {4'h0, linked}, 8'h00);
  endtask : t_reset

  task automatic t_alert;
    @(posedge clk);
    other <= 8'h01;
    repeat (3) @(negedge clk);
    chk("alert on", {7'h0, alert_n}, 8'h00);
    i_tmc_host.wr(`TMC_A_MAIN, 8'h80);
    repeat (2) @(negedge clk);
    chk("alert masked", {7'h0, alert_n}, 8'h01);
    i_tmc_host.wr(`TMC_A_MAIN, 8'h00);
    @(posedge clk);
    other <= 8'h00;
  endtask : t_alert

  task automatic t_lock;
    @(posedge clk);
    sw_lock <= 1'b1;
    i_tmc_host.wr(`TMC_A_MAIN, 8'h81);
    i_tmc_host.wr(`TMC_A_CONV, 8'h00);
    i_tmc_host.wr(`TMC_A_REC, 8'h00);
    chk("main locked", main_cfg, 8'h00);
    chk("conv locked", conv_cfg, 8'h0E);
    i_tmc_host.rd(`TMC_A_REC, d);
    chk("rec locked", d, 8'h04);
    @(posedge clk);
    sw_lock <= 1'b0;
    i_tmc_host.wr(`TMC_A_CONV, 8'h6E);
    chk("conv bits", conv_cfg, 8'h6E);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0E);
  endtask : t_lock

  task automatic t_rec_ro;
    @(posedge clk);
    hw_chan <= SHDN_EXT1;
    pin <= 1'b1;
    i_tmc_host.wr(`TMC_A_REC, 8'h02);
    @(negedge clk);
    i_tmc_host.rd(`TMC_A_REC, d);
    chk("rec read only", d, 8'h03);
    chk("rec outputs", {5'h0, rec_en}, 8'h03);
    @(posedge clk);
    hw_chan <= SHDN_NONE;
  endtask : t_rec_ro

  task automatic t_crit;
    i_tmc_host.wr(`TMC_A_CRIT_E1, 8'h50);
    chk("link ext1", {4'h0, linked}, 8'h02);
    i_tmc_host.wr(`TMC_A_CRIT_E1, 8'h20);
    i_tmc_host.rd(`TMC_A_CRIT_E1, d);
    chk("limit locked", d, 8'h50);
    feed(1, 8'h64, 4);
    chk("crit shutdown", {7'h0, shdn}, 8'h01);
    chk("crit summary", {7'h0, tsum}, 8'h01);
    feed(1, 8'h20, 4);
    chk("crit release", {7'h0, shdn}, 8'h00);
    chk("status sticky", {7'h0, tsum}, 8'h01);
    i_tmc_host.rd(`TMC_A_CRIT_ST, d);
    chk("crit status", d, 8'h02);
    @(negedge clk);
    chk("status cleared", {7'h0, tsum}, 8'h00);
  endtask : t_crit

  task automatic t_high;
    i_tmc_host.wr(`TMC_A_MAIN, 8'h04);
    feed(2, 8'h40, 4);
    chk("high at limit", {7'h0, shdn}, 8'h01);
    feed(2, 8'h3F, 4);
    chk("high release", {7'h0, shdn}, 8'h00);
    i_tmc_host.wr(`TMC_A_MAIN, 8'h00);
  endtask : t_high

  task automatic t_mean;
    feed(3, 8'h08, 1);
    feed(3, 8'h10, 1);
    feed(3, 8'h18, 1);
    feed(3, 8'h20, 1);
    chk("mean of four", rep[3], 8'h14);
    i_tmc_host.wr(`TMC_A_CONV, 8'h1E);
    feed(3, 8'h30, 1);
    chk("latest only", rep[3], 8'h30);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0E);
  endtask : t_mean

  task automatic t_queue;
    i_tmc_host.wr(`TMC_A_CONV, 8'h02);
    feed(0, 8'h40, 1);
    chk("depth one", {7'h0, qt}, 8'h01);
    i_tmc_host.wr(`TMC_A_CONV, 8'h06);
    feed(0, 8'h40, 1);
    chk("depth two first", {7'h0, qt}, 8'h00);
    feed(0, 8'h40, 1);
    chk("depth two second", {7'h0, qt}, 8'h01);
    feed(0, 8'h10, 1);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0A);
    feed(0, 8'h40, 1);
    chk("depth three first", {7'h0, qt}, 8'h00);
    i_tmc_host.wr(`TMC_A_CONV, 8'h02);
    feed(0, 8'h40, 1);
    chk("depth kept while active", {7'h0, qt}, 8'h00);
    feed(0, 8'h40, 1);
    chk("depth three third", {7'h0, qt}, 8'h01);
    feed(0, 8'h10, 1);
  endtask : t_queue

  task automatic t_rate;
    i_tmc_host.wr(`TMC_A_CONV, 8'h0E);
    period(10);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0C);
    period(40);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0D);
    period(20);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0F);
    @(posedge clk);
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    chk("tick on update", {7'h0, tick}, 8'h01);
    @(negedge clk);
    chk("tick single", {7'h0, tick}, 8'h00);
    i_tmc_host.wr(`TMC_A_CONV, 8'h0E);
  endtask : t_rate

  task automatic t_apd;
    i_tmc_host.wr(`TMC_A_MAIN, 8'h01);
    chk("apd cfg", main_cfg, 8'h01);
    chk("ext3 held", {7'h0, cmp3}, 8'h00);
    feed(3, 8'h10, 2);
    chk("ext3 live", {7'h0, cmp3}, 8'h01);
  endtask : t_apd

  // limits unlock only on reset; a low enable freezes the registers
  task automatic t_por;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("por unlinked", {4'h0, linked}, 8'h00);
    chk("por ext3 compare", {7'h0, cmp3}, 8'h01);
    chk("por alert", {7'h0, alert_n}, 8'h01);
    i_tmc_host.wr(`TMC_A_CRIT_E1, 8'h30);
    i_tmc_host.rd(`TMC_A_CRIT_E1, d);
    chk("limit after por", d, 8'h30);
    @(posedge clk);
    ce <= 1'b0;
    i_tmc_host.wr(`TMC_A_MAIN, 8'h80);
    chk("frozen", main_cfg, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_por

  // ==========================================================
  // run control
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #400us;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_alert();
    t_lock();
    t_rec_ro();
    t_crit();
    t_high();
    t_mean();
    t_queue();
    t_rate();
    t_apd();
    t_por();
    end_of_test();
  end
endmodule : tb_tmc_config_shutdown
